// ### logic/dppc_pkg.sv
/*
 * Package for the dual pin port block: data-space addresses, field positions,
 * reset values and the trigger encodings of the combined port interrupts.
 * Assumes an 8-bit data-space port with byte addresses.
 */
package dppc_pkg;

   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DATA_W  = 8;

   // Data-space addresses of the port registers.
   localparam logic [7:0] ADDR_PORT_A_DATA      = 8'hc0;
   localparam logic [7:0] ADDR_PORT_B_DATA      = 8'hc1;
   localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'hc4;
   localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'hc5;
   localparam logic [7:0] ADDR_INT_OPTION       = 8'hc8;
   localparam logic [7:0] ADDR_PORT_A_OPTION    = 8'hcc;
   localparam logic [7:0] ADDR_PORT_B_OPTION    = 8'hcd;

   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [7:0] IOR_RESET  = 8'h00;
   localparam logic [7:0] RDATA_ZERO = 8'h00;

   // Interrupt option register layout.
   localparam int unsigned IOR_TRIG_A_LSB = 0;
   localparam int unsigned IOR_TRIG_B_LSB = 2;
   localparam int unsigned IOR_GEN_BIT    = 4;
   localparam logic [7:0]  IOR_WMASK      = 8'h1f;

   // Lines with special functions.
   localparam int unsigned HIGH_SINK_N   = 4;
   localparam int unsigned ANALOG_LSB    = 4;
   localparam int unsigned ANALOG_N      = 4;
   localparam int unsigned LINE_ZERO     = 0;

   typedef enum logic [1:0] {
      DPPC_TRIG_FALL,
      DPPC_TRIG_RISE,
      DPPC_TRIG_LOW,
      DPPC_TRIG_LOW_ALT
   } dppc_trig_t;

endpackage

// ### logic/dppc_port_block.sv
/*
 * Two 8-line pin ports with per-line data, direction and option registers,
 * a shared interrupt option register and the two AND-combined port
 * interrupt requests. Assumes a single-cycle data-space port from the core
 * and external pad cells that resolve output, enable and pull-up per line.
 */
`timescale 1ns/1ps

module dppc_port_block #(
   parameter bit STOP_CTRL_OPTION = 1'b0
) (
   input  wire logic                           ref_clk_i,
   input  wire logic                           rst_n_i,
   input  wire logic [dppc_pkg::ADDR_W-1:0]    addr_i,
   input  wire logic [dppc_pkg::DATA_W-1:0]    wdata_i,
   input  wire logic                           wr_en_i,
   input  wire logic                           rd_en_i,
   output logic      [dppc_pkg::DATA_W-1:0]    rdata_o,
   input  wire logic [7:0]                     port_a_pin_i,
   output logic      [7:0]                     port_a_pin_o,
   output logic      [7:0]                     port_a_pin_oe_o,
   output logic      [7:0]                     port_a_pullup_o,
   output logic      [dppc_pkg::HIGH_SINK_N-1:0] port_a_high_sink_lines_o,
   input  wire logic [7:0]                     port_b_lines_i,
   output logic      [7:0]                     port_b_lines_o,
   output logic      [7:0]                     port_b_lines_oe_o,
   output logic      [7:0]                     port_b_pullup_o,
   output logic      [dppc_pkg::ANALOG_N-1:0]  port_b_analog_lines_o,
   output logic                                port_a_irq_o,
   output logic                                port_b_irq_o,
   output logic                                global_interrupt_enable_o
);
   import dppc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   logic [7:0] port_a_data_ff;
   logic [7:0] nxt_port_a_data;
   logic [7:0] port_b_data_ff;
   logic [7:0] nxt_port_b_data;
   logic [7:0] port_a_direction_ff;
   logic [7:0] nxt_port_a_direction;
   logic [7:0] port_b_direction_ff;
   logic [7:0] nxt_port_b_direction;
   logic [7:0] port_a_option_ff;
   logic [7:0] nxt_port_a_option;
   logic [7:0] port_b_option_ff;
   logic [7:0] nxt_port_b_option;
   logic [7:0] interrupt_option_register_ff;
   logic [7:0] nxt_interrupt_option_register;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic [7:0] port_a_in;
   logic [7:0] port_b_in;
   logic [7:0] b_fixed_mask;

   // With the stop control option fitted, line zero of port B belongs to the
   // power controller, so its register bits hold at zero and read as zero.
   assign b_fixed_mask = STOP_CTRL_OPTION ? (8'h01 << LINE_ZERO) : 8'h00;

   always_comb begin
      nxt_port_a_data               = port_a_data_ff;
      nxt_port_b_data               = port_b_data_ff;
      nxt_port_a_direction          = port_a_direction_ff;
      nxt_port_b_direction          = port_b_direction_ff;
      nxt_port_a_option             = port_a_option_ff;
      nxt_port_b_option             = port_b_option_ff;
      nxt_interrupt_option_register = interrupt_option_register_ff;
      nxt_rdata                     = rdata_ff;
      if (wr_en_i) begin
         if (addr_i == ADDR_PORT_A_DATA) begin
            nxt_port_a_data = wdata_i;
         end else if (addr_i == ADDR_PORT_B_DATA) begin
            nxt_port_b_data = wdata_i & ~b_fixed_mask;
         end else if (addr_i == ADDR_PORT_A_DIRECTION) begin
            nxt_port_a_direction = wdata_i;
         end else if (addr_i == ADDR_PORT_B_DIRECTION) begin
            nxt_port_b_direction = wdata_i & ~b_fixed_mask;
         end else if (addr_i == ADDR_PORT_A_OPTION) begin
            nxt_port_a_option = wdata_i;
         end else if (addr_i == ADDR_PORT_B_OPTION) begin
            nxt_port_b_option = wdata_i & ~b_fixed_mask;
         end else if (addr_i == ADDR_INT_OPTION) begin
            nxt_interrupt_option_register = wdata_i & IOR_WMASK;
         end
      end
      if (rd_en_i) begin
         // Input lines read the pin, output lines read the latch.
         if (addr_i == ADDR_PORT_A_DATA) begin
            nxt_rdata = (port_a_direction_ff & port_a_data_ff) | (~port_a_direction_ff & port_a_in);
         end else if (addr_i == ADDR_PORT_B_DATA) begin
            nxt_rdata = ((port_b_direction_ff & port_b_data_ff) | (~port_b_direction_ff & port_b_in))
                        & ~b_fixed_mask;
         end else if (addr_i == ADDR_PORT_A_DIRECTION) begin
            nxt_rdata = port_a_direction_ff;
         end else if (addr_i == ADDR_PORT_B_DIRECTION) begin
            nxt_rdata = port_b_direction_ff;
         end else if (addr_i == ADDR_PORT_A_OPTION) begin
            nxt_rdata = port_a_option_ff;
         end else if (addr_i == ADDR_PORT_B_OPTION) begin
            nxt_rdata = port_b_option_ff;
         end else if (addr_i == ADDR_INT_OPTION) begin
            nxt_rdata = interrupt_option_register_ff;
         end else begin
            nxt_rdata = RDATA_ZERO;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         port_a_data_ff               <= PORT_RESET;
         port_b_data_ff               <= PORT_RESET;
         port_a_direction_ff          <= PORT_RESET;
         port_b_direction_ff          <= PORT_RESET;
         port_a_option_ff             <= PORT_RESET;
         port_b_option_ff             <= PORT_RESET;
         interrupt_option_register_ff <= IOR_RESET;
         rdata_ff                     <= RDATA_ZERO;
      end else begin
         port_a_data_ff               <= nxt_port_a_data;
         port_b_data_ff               <= nxt_port_b_data;
         port_a_direction_ff          <= nxt_port_a_direction;
         port_b_direction_ff          <= nxt_port_b_direction;
         port_a_option_ff             <= nxt_port_a_option;
         port_b_option_ff             <= nxt_port_b_option;
         interrupt_option_register_ff <= nxt_interrupt_option_register;
         rdata_ff                     <= nxt_rdata;
      end
   end

   assign rdata_o = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers. A new level is accepted once stages two and three
   // agree, which also filters a single-cycle glitch on the pad.

   logic [7:0] a_s1_ff;
   logic [7:0] a_s2_ff;
   logic [7:0] a_s3_ff;
   logic [7:0] a_in_ff;
   logic [7:0] nxt_a_in;
   logic [7:0] b_s1_ff;
   logic [7:0] b_s2_ff;
   logic [7:0] b_s3_ff;
   logic [7:0] b_in_ff;
   logic [7:0] nxt_b_in;

   always_comb begin
      nxt_a_in = (a_s2_ff & a_s3_ff) | (a_in_ff & (a_s2_ff ^ a_s3_ff));
      nxt_b_in = (b_s2_ff & b_s3_ff) | (b_in_ff & (b_s2_ff ^ b_s3_ff));
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_s1_ff <= PORT_RESET;
         a_s2_ff <= PORT_RESET;
         a_s3_ff <= PORT_RESET;
         a_in_ff <= PORT_RESET;
         b_s1_ff <= PORT_RESET;
         b_s2_ff <= PORT_RESET;
         b_s3_ff <= PORT_RESET;
         b_in_ff <= PORT_RESET;
      end else begin
         a_s1_ff <= port_a_pin_i;
         a_s2_ff <= a_s1_ff;
         a_s3_ff <= a_s2_ff;
         a_in_ff <= nxt_a_in;
         b_s1_ff <= port_b_lines_i;
         b_s2_ff <= b_s1_ff;
         b_s3_ff <= b_s2_ff;
         b_in_ff <= nxt_b_in;
      end
   end

   assign port_a_in = a_in_ff;
   assign port_b_in = b_in_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Per-line mode decode: direction, option, data select the pad behaviour.

   logic [7:0] a_out;
   logic [7:0] a_oe;
   logic [7:0] a_pu;
   logic [7:0] a_ien;
   logic [7:0] b_out;
   logic [7:0] b_oe;
   logic [7:0] b_pu;
   logic [7:0] b_ien;
   logic [7:0] b_ana;

   for (genvar n = 0; n < 8; n++) begin : g_line
      // Output: push-pull drives both levels, open-drain only pulls low.
      assign a_out[n] = port_a_direction_ff[n] & port_a_option_ff[n] & port_a_data_ff[n];
      assign a_oe[n]  = port_a_direction_ff[n]
                        & (port_a_option_ff[n] | ~port_a_data_ff[n]);
      assign a_pu[n]  = ~port_a_direction_ff[n] & ~port_a_data_ff[n];
      assign a_ien[n] = ~port_a_direction_ff[n] & port_a_option_ff[n] & ~port_a_data_ff[n];
      assign b_out[n] = port_b_direction_ff[n] & port_b_option_ff[n] & port_b_data_ff[n];
      assign b_oe[n]  = port_b_direction_ff[n]
                        & (port_b_option_ff[n] | ~port_b_data_ff[n]);
      assign b_pu[n]  = ~port_b_direction_ff[n] & ~port_b_data_ff[n] & ~b_fixed_mask[n];
      assign b_ien[n] = ~port_b_direction_ff[n] & port_b_option_ff[n] & ~port_b_data_ff[n];
      // Port B lines 0 to 3 in the analog setting stay plain inputs.
      if (n >= ANALOG_LSB) begin : g_ana
         assign b_ana[n] = ~port_b_direction_ff[n] & port_b_option_ff[n] & port_b_data_ff[n];
      end else begin : g_dig
         assign b_ana[n] = 1'b0;
      end
   end

   logic [7:0]             a_pin_ff;
   logic [7:0]             a_oe_ff;
   logic [7:0]             a_pu_ff;
   logic [7:0]             b_pin_ff;
   logic [7:0]             b_oe_ff;
   logic [7:0]             b_pu_ff;
   logic [HIGH_SINK_N-1:0] a_hs_ff;
   logic [HIGH_SINK_N-1:0] nxt_a_hs;
   logic [ANALOG_N-1:0]    b_ana_ff;

   always_comb begin
      nxt_a_hs = port_a_direction_ff[HIGH_SINK_N-1:0];
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_pin_ff <= PORT_RESET;
         a_oe_ff  <= PORT_RESET;
         a_pu_ff  <= PORT_RESET;
         a_hs_ff  <= '0;
         b_pin_ff <= PORT_RESET;
         b_oe_ff  <= PORT_RESET;
         b_pu_ff  <= PORT_RESET;
         b_ana_ff <= '0;
      end else begin
         a_pin_ff <= a_out;
         a_oe_ff  <= a_oe;
         a_pu_ff  <= a_pu;
         a_hs_ff  <= nxt_a_hs;
         b_pin_ff <= b_out;
         b_oe_ff  <= b_oe;
         b_pu_ff  <= b_pu;
         b_ana_ff <= b_ana[ANALOG_LSB +: ANALOG_N];
      end
   end

   assign port_a_pin_o             = a_pin_ff;
   assign port_a_pin_oe_o          = a_oe_ff;
   assign port_a_pullup_o          = a_pu_ff;
   assign port_a_high_sink_lines_o = a_hs_ff;
   assign port_b_lines_o           = b_pin_ff;
   assign port_b_lines_oe_o        = b_oe_ff;
   assign port_b_pullup_o          = b_pu_ff;
   assign port_b_analog_lines_o    = b_ana_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Combined port interrupts. Lines not enabled count as high, so a port
   // with no enabled line never requests. Edges are taken on the combined
   // level, so a second line falling while another is already low is lost.

   logic       a_comb;
   logic       b_comb;
   logic       a_any;
   logic       b_any;
   logic       a_comb_ff;
   logic       b_comb_ff;
   logic       nxt_a_comb;
   logic       nxt_b_comb;
   logic       a_irq_ff;
   logic       b_irq_ff;
   logic       gen_ff;
   logic       nxt_a_irq;
   logic       nxt_b_irq;
   logic       nxt_gen;
   dppc_trig_t trig_a;
   dppc_trig_t trig_b;

   assign a_comb = &(port_a_in | ~a_ien);
   assign b_comb = &(port_b_in | ~b_ien);
   assign a_any  = |a_ien;
   assign b_any  = |b_ien;
   assign trig_a = dppc_trig_t'(interrupt_option_register_ff[IOR_TRIG_A_LSB +: 2]);
   assign trig_b = dppc_trig_t'(interrupt_option_register_ff[IOR_TRIG_B_LSB +: 2]);

   always_comb begin
      nxt_a_comb = a_comb;
      nxt_b_comb = b_comb;
      nxt_gen    = interrupt_option_register_ff[IOR_GEN_BIT];
      case (trig_a)
         DPPC_TRIG_FALL: nxt_a_irq = a_comb_ff & ~a_comb;
         DPPC_TRIG_RISE: nxt_a_irq = ~a_comb_ff & a_comb & a_any;
         default:        nxt_a_irq = ~a_comb;
      endcase
      case (trig_b)
         DPPC_TRIG_FALL: nxt_b_irq = b_comb_ff & ~b_comb;
         DPPC_TRIG_RISE: nxt_b_irq = ~b_comb_ff & b_comb & b_any;
         default:        nxt_b_irq = ~b_comb;
      endcase
      nxt_a_irq = nxt_a_irq & nxt_gen;
      nxt_b_irq = nxt_b_irq & nxt_gen;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_comb_ff <= 1'b1;
         b_comb_ff <= 1'b1;
         a_irq_ff  <= 1'b0;
         b_irq_ff  <= 1'b0;
         gen_ff    <= 1'b0;
      end else begin
         a_comb_ff <= nxt_a_comb;
         b_comb_ff <= nxt_b_comb;
         a_irq_ff  <= nxt_a_irq;
         b_irq_ff  <= nxt_b_irq;
         gen_ff    <= nxt_gen;
      end
   end

   assign port_a_irq_o              = a_irq_ff;
   assign port_b_irq_o              = b_irq_ff;
   assign global_interrupt_enable_o = gen_ff;

endmodule // dppc_port_block

// ### verif/dppc_port_block_properties.sv
/*
 * Checker for the dual pin port block: shadows the register writes and ties
 * pin outputs, the port A direction read and interrupt gating to them.
 * Assumes it is bound to dppc_port_block and sees only its ports.
 */
`timescale 1ns/1ps
module dppc_props_chk
   import dppc_pkg::*;
#(
   parameter bit STOP_CTRL_OPTION = 1'b0
) (
   input wire logic       ref_clk_i,
   input wire logic       rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_en_i,
   input wire logic       rd_en_i,
   input wire logic [7:0] rdata_o,
   input wire logic [7:0] port_a_pin_o,
   input wire logic [7:0] port_a_pin_oe_o,
   input wire logic [7:0] port_a_pullup_o,
   input wire logic [3:0] port_a_high_sink_lines_o,
   input wire logic [7:0] port_b_lines_o,
   input wire logic [7:0] port_b_lines_oe_o,
   input wire logic [7:0] port_b_pullup_o,
   input wire logic [3:0] port_b_analog_lines_o,
   input wire logic       port_a_irq_o,
   input wire logic       port_b_irq_o,
   input wire logic       global_interrupt_enable_o
);
   logic [1:0][7:0] dir_ff, opt_ff, dat_ff, oe_x, pp_x, pu_x;
   logic [3:0]      an_x;
   logic [1:0]      up_ff;
   logic            gen_ff;

   // Outputs lag the registers by one edge, so the checks gated by up_ff wait two edges after reset.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {dir_ff, opt_ff, dat_ff, gen_ff, up_ff} <= '0;
      end else begin
         up_ff <= {up_ff[0], 1'b1};
         if (wr_en_i) begin
            case (addr_i)
               ADDR_PORT_A_DATA:      dat_ff[0] <= wdata_i;
               ADDR_PORT_B_DATA:      dat_ff[1] <= wdata_i;
               ADDR_PORT_A_DIRECTION: dir_ff[0] <= wdata_i;
               ADDR_PORT_B_DIRECTION: dir_ff[1] <= wdata_i;
               ADDR_PORT_A_OPTION:    opt_ff[0] <= wdata_i;
               ADDR_PORT_B_OPTION:    opt_ff[1] <= wdata_i;
               ADDR_INT_OPTION:       gen_ff <= wdata_i[IOR_GEN_BIT];
               default:               ;
            endcase
         end
      end
   end

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         oe_x[p] = dir_ff[p] & (opt_ff[p] | ~dat_ff[p]);
         pp_x[p] = dir_ff[p] & opt_ff[p] & dat_ff[p];
         pu_x[p] = ~dir_ff[p] & ~dat_ff[p];
      end
      an_x = ~dir_ff[1][7:4] & opt_ff[1][7:4] & dat_ff[1][7:4];
      if (STOP_CTRL_OPTION) begin
         oe_x[1][0] = 1'b0;
         pp_x[1][0] = 1'b0;
         pu_x[1][0] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_oe_port_a: assert property (up_ff[1] |-> port_a_pin_oe_o == $past(oe_x[0]))
      else $error("port A drive enable differs from configuration");
   a_oe_port_b: assert property (up_ff[1] |-> port_b_lines_oe_o == $past(oe_x[1]))
      else $error("port B drive enable differs from configuration");
   a_drive_latch_a: assert property (up_ff[1] |-> (port_a_pin_o & port_a_pin_oe_o) == $past(pp_x[0]))
      else $error("port A driven level differs from data latch");
   a_drive_latch_b: assert property (up_ff[1] |-> (port_b_lines_o & port_b_lines_oe_o) == $past(pp_x[1]))
      else $error("port B driven level differs from data latch");
   a_pullup_port_a: assert property (up_ff[1] |-> port_a_pullup_o == $past(pu_x[0]))
      else $error("port A pull-up differs from configuration");
   a_pullup_port_b: assert property (up_ff[1] |-> port_b_pullup_o == $past(pu_x[1]))
      else $error("port B pull-up differs from configuration");
   a_analog_sel: assert property (up_ff[1] |-> port_b_analog_lines_o == $past(an_x))
      else $error("analog selection differs from configuration");
   a_high_sink_sel: assert property (up_ff[1] |-> port_a_high_sink_lines_o == $past(dir_ff[0][3:0]))
      else $error("high sink selection differs from direction");
   a_gen_copy: assert property (up_ff[1] |-> global_interrupt_enable_o == $past(gen_ff))
      else $error("global enable output differs from written bit");
   a_irq_gated: assert property ((!gen_ff) [*4] |-> !(port_a_irq_o || port_b_irq_o))
      else $error("port request while global enable is off");
   a_read_dir: assert property (rd_en_i && addr_i == ADDR_PORT_A_DIRECTION |=> rdata_o == $past(dir_ff[0]))
      else $error("direction read returns wrong value");

   c_irq_a: cover property (port_a_irq_o);
   c_irq_b: cover property (port_b_irq_o);
   c_analog: cover property (|port_b_analog_lines_o);
endmodule // dppc_props_chk

bind dppc_port_block dppc_props_chk #(.STOP_CTRL_OPTION(STOP_CTRL_OPTION)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_en_i(wr_en_i),
   .rd_en_i(rd_en_i), .rdata_o(rdata_o), .port_a_pin_o(port_a_pin_o), .port_a_pin_oe_o(port_a_pin_oe_o),
   .port_a_pullup_o(port_a_pullup_o), .port_a_high_sink_lines_o(port_a_high_sink_lines_o),
   .port_b_lines_o(port_b_lines_o), .port_b_lines_oe_o(port_b_lines_oe_o), .port_b_pullup_o(port_b_pullup_o),
   .port_b_analog_lines_o(port_b_analog_lines_o), .port_a_irq_o(port_a_irq_o), .port_b_irq_o(port_b_irq_o),
   .global_interrupt_enable_o(global_interrupt_enable_o));

// ### verif/dppc_pin_model.sv
/*
 * External pads of one port: resolve drive, outside drivers and pull-up.
 * Assumes the bench never drives a line that the block drives.
 */
`timescale 1ns/1ps
module dppc_pin_model (
   input  wire logic       ref_clk_i,
   input  wire logic [7:0] pin_i,
   input  wire logic [7:0] oe_i,
   input  wire logic [7:0] pullup_i,
   input  wire logic [7:0] ext_en_i,
   input  wire logic [7:0] ext_val_i,
   output logic      [7:0] pad_o
);
   logic [7:0] float_ff = 8'h55;
   logic [7:0] free;

   // A floating line toggles so that no settled value can pass for a real one.
   always_ff @(posedge ref_clk_i) float_ff <= ~float_ff;
   assign free  = ~oe_i & ~ext_en_i;
   assign pad_o = (oe_i & pin_i) | (~oe_i & ext_en_i & ext_val_i) | (free & pullup_i) | (free & ~pullup_i & float_ff);
endmodule // dppc_pin_model

// ### verif/testbench.sv
/*
 * Self-checking bench for the dual pin port block: configuration table,
 * reset state, pin reads and the combined port interrupts.
 * Assumes the checker is bound in and the pads are modelled per port.
 */
`timescale 1ns/1ps
module testbench;
   import dppc_pkg::*;
   typedef struct packed {logic [7:0] dir, opt, dat, oe, pin, pu; logic [3:0] an;} dppc_row_t;
   logic       ref_clk_i = 1'b0, rst_n_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, a_pin, a_oe, a_pu, b_pin, b_oe, b_pu, pad_a, pad_b;
   logic [7:0] ext_en [2] = '{8'h00, 8'h00};
   logic [7:0] ext_val [2] = '{8'h00, 8'h00};
   logic [3:0] a_hs, b_an;
   logic [7:0] rdata_fixed, fixed_pu;
   logic       a_irq, b_irq, gen_o;
   int         error_cnt = 0, n_checks = 0;
   dppc_row_t  rows [6] = '{'{8'hff, 8'h00, 8'h0f, 8'hf0, 8'h00, 8'h00, 4'h0},
      '{8'hff, 8'hff, 8'h5a, 8'hff, 8'h5a, 8'h00, 4'h0}, '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 4'h0},
      '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 4'h0}, '{8'h00, 8'h10, 8'h10, 8'h00, 8'h00, 8'hef, 4'h1},
      '{8'h0f, 8'h33, 8'h55, 8'h0b, 8'h01, 8'ha0, 4'h1}};

   always #2.5 ref_clk_i = ~ref_clk_i;

   dppc_port_block DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o), .port_a_pin_i(pad_a), .port_a_pin_o(a_pin),
      .port_a_pin_oe_o(a_oe), .port_a_pullup_o(a_pu), .port_a_high_sink_lines_o(a_hs), .port_b_lines_i(pad_b),
      .port_b_lines_o(b_pin), .port_b_lines_oe_o(b_oe), .port_b_pullup_o(b_pu), .port_b_analog_lines_o(b_an),
      .port_a_irq_o(a_irq), .port_b_irq_o(b_irq), .global_interrupt_enable_o(gen_o));
   dppc_pin_model pm_a (.ref_clk_i(ref_clk_i), .pin_i(a_pin), .oe_i(a_oe), .pullup_i(a_pu),
      .ext_en_i(ext_en[0]), .ext_val_i(ext_val[0]), .pad_o(pad_a));
   dppc_pin_model pm_b (.ref_clk_i(ref_clk_i), .pin_i(b_pin), .oe_i(b_oe), .pullup_i(b_pu),
      .ext_en_i(ext_en[1]), .ext_val_i(ext_val[1]), .pad_o(pad_b));
   // Second copy with port B line zero held by the stop controller; it shares the register strobes.
   dppc_port_block #(.STOP_CTRL_OPTION(1'b1)) DUT_FIXED (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_fixed), .port_a_pin_i(pad_a),
      .port_a_pin_o(), .port_a_pin_oe_o(), .port_a_pullup_o(), .port_a_high_sink_lines_o(), .port_b_lines_i(pad_b),
      .port_b_lines_o(), .port_b_lines_oe_o(), .port_b_pullup_o(fixed_pu), .port_b_analog_lines_o(),
      .port_a_irq_o(), .port_b_irq_o(), .global_interrupt_enable_o());

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_en_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_en_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk_i);
      addr_i  <= a;
      rd_en_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_en_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   task automatic drv(input int p, input logic [7:0] en, input logic [7:0] val);
      @(posedge ref_clk_i);
      ext_en[p]  <= en;
      ext_val[p] <= val;
   endtask
   // Edge requests last one cycle, so every cycle of the window is looked at.
   task automatic irq_seen(input int p, input logic exp, input string what);
      logic hit;
      hit = 1'b0;
      repeat (12) begin
         @(posedge ref_clk_i);
         #1 hit |= (p != 0) ? b_irq : a_irq;
      end
      chk({7'h00, hit}, {7'h00, exp}, what);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] v;
      static logic [7:0] ra [7] = '{ADDR_PORT_A_DATA, ADDR_PORT_B_DATA, ADDR_PORT_A_DIRECTION, ADDR_PORT_B_DIRECTION,
                             ADDR_PORT_A_OPTION, ADDR_PORT_B_OPTION, ADDR_INT_OPTION};
      static logic [7:0] re [7] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      #1 chk(a_pu & b_pu, 8'hff, "reset pull-up");
      chk(a_oe | b_oe, 8'h00, "reset drive");
      chk(fixed_pu, 8'hfe, "fixed line pull-up");
      foreach (ra[i]) begin
         rd(ra[i], v);
         chk(v, re[i], "reset read");
      end
      // At most one analog line per row keeps the converter inputs apart.
      for (int p = 0; p < 2; p++) foreach (rows[i]) begin
         wr(ADDR_PORT_A_DIRECTION + 8'(p), rows[i].dir);
         wr(ADDR_PORT_A_OPTION + 8'(p), rows[i].opt);
         wr(ADDR_PORT_A_DATA + 8'(p), rows[i].dat);
         repeat (2) @(posedge ref_clk_i);
         #1 chk((p != 0) ? b_oe : a_oe, rows[i].oe, "drive enable");
         chk((p != 0) ? b_pin & b_oe : a_pin & a_oe, rows[i].pin, "driven level");
         chk((p != 0) ? b_pu : a_pu, rows[i].pu, "pull-up");
         chk((p != 0) ? {4'h0, b_an} : {4'h0, a_hs}, {4'h0, (p != 0) ? rows[i].an : rows[i].dir[3:0]}, "special");
         rd(ADDR_PORT_A_OPTION + 8'(p), v);
         chk(v, rows[i].opt, "option read");
         if (p != 0) chk(rdata_fixed, rows[i].opt & 8'hfe, "fixed line option");
      end
      wr(ADDR_PORT_A_DIRECTION, 8'h00);
      wr(ADDR_PORT_A_DATA, 8'hff);
      drv(0, 8'hff, 8'h3c);
      repeat (6) @(posedge ref_clk_i);
      rd(ADDR_PORT_A_DATA, v);
      chk(v, 8'h3c, "pin read");
      for (int p = 0; p < 2; p++) begin
         drv(p, 8'h00, 8'h00);
         wr(ADDR_PORT_A_DIRECTION + 8'(p), 8'h00);
         wr(ADDR_PORT_A_DATA + 8'(p), 8'h00);
         wr(ADDR_PORT_A_OPTION + 8'(p), 8'h03);
         wr(ADDR_INT_OPTION, 8'h10);
         irq_seen(p, 1'b0, "idle");
         drv(p, 8'h04, 8'h00);
         irq_seen(p, 1'b0, "line without interrupt");
         drv(p, 8'h05, 8'h00);
         irq_seen(p, 1'b1, "falling");
         wr(ADDR_INT_OPTION, 8'h10 | (8'h01 << (2 * p)));
         drv(p, 8'h04, 8'h00);
         irq_seen(p, 1'b1, "rising");
         wr(ADDR_INT_OPTION, 8'h02 << (2 * p));
         drv(p, 8'h05, 8'h00);
         irq_seen(p, 1'b0, "masked");
         wr(ADDR_INT_OPTION, 8'h10 | (8'h02 << (2 * p)));
         irq_seen(p, 1'b1, "low level");
         chk({7'h00, (p != 0) ? b_irq : a_irq}, 8'h01, "level held");
         drv(p, 8'h00, 8'h00);
      end
      wr(ADDR_INT_OPTION, 8'hff);
      drv(0, 8'h01, 8'h00);
      irq_seen(0, 1'b1, "low level alternate code");
      rd(ADDR_INT_OPTION, v);
      chk(v, 8'h1f, "interrupt option read");
      wr(8'hc3, 8'h55);
      rd(8'hc3, v);
      chk(v, RDATA_ZERO, "unmapped read");
      end_of_test();
   end

   // The run needs about 360 cycles; a limit of 10000 cycles marks a hang.
   initial begin
      #50000;
      error_cnt++;
      end_of_test();
   end
endmodule // testbench
